//--- hw/metering_cfg_pkg.sv
// Constants and state type for the metering configuration bank
package metering_cfg_pkg;

  localparam int NREG = 8;

  localparam logic [2:0] IDX_ENGINE = 3'h0;
  localparam logic [2:0] IDX_CHOP = 3'h1;
  localparam logic [2:0] IDX_CONV = 3'h2;
  localparam logic [2:0] IDX_BATT = 3'h3;
  localparam logic [2:0] IDX_BOOT = 3'h4;
  localparam logic [2:0] IDX_LOC = 3'h5;
  localparam logic [2:0] IDX_IGLOB = 3'h6;
  localparam logic [2:0] IDX_ICHAN = 3'h7;

  // Byte addresses, index 7 first
  localparam logic [NREG-1:0][15:0] REG_ADDR = {
    16'h20AC, 16'h20AB, 16'h20A8, 16'h20A7,
    16'h2020, 16'h2005, 16'h2002, 16'h2000};

  // Implemented bits of each register
  localparam logic [NREG-1:0][7:0] FIELD_MASK = {
    8'h11, 8'h01, 8'h1F, 8'hFF, 8'h40, 8'h08, 8'h30, 8'h18};

  localparam logic [NREG-1:0][7:0] RESET_VAL = {
    8'h00, 8'h00, 8'h1F, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

  // Bits loaded at wake; others hold (undefined or backup supplied)
  localparam logic [NREG-1:0][7:0] WAKE_MASK = {
    8'h11, 8'h01, 8'h1F, 8'hFF, 8'h00, 8'h08, 8'h30, 8'h18};

  // Display bits lost in sleep, and write-only bits
  localparam logic [NREG-1:0][7:0] LOSE_MASK = {NREG{8'h00}};
  localparam logic [NREG-1:0][7:0] WO_MASK = {NREG{8'h00}};

  localparam int FAST_BIT = 3;
  localparam int CE_EN_BIT = 4;
  localparam int CHOP_LSB = 4;
  localparam int CONV_BIT = 3;
  localparam int BME_BIT = 6;
  localparam int IGLOB_BIT = 0;
  localparam int IA_BIT = 0;
  localparam int IB_BIT = 4;
  localparam int PAGE_SHIFT = 10;

  localparam int CLK_HZ = 20_000_000;
  localparam int ENGINE_FAST_HZ = 10_000_000;
  localparam int ENGINE_SLOW_HZ = 5_000_000;
  localparam logic [1:0] FAST_LAST = 2'(CLK_HZ / ENGINE_FAST_HZ - 1);
  localparam logic [1:0] SLOW_LAST = 2'(CLK_HZ / ENGINE_SLOW_HZ - 1);

  typedef enum logic [1:0] {
    CHOP_TOGGLE_ALT = 2'h0,
    CHOP_POSITIVE = 2'h1,
    CHOP_REVERSED = 2'h2,
    CHOP_TOGGLE = 2'h3
  } chop_mode_t;

  typedef struct packed {
    logic [NREG-1:0][7:0] bank;
    logic [7:0] rdata;
    logic sync_d;
    logic chop_pol;
    logic alt_req;
    logic [1:0] div;
    logic tick;
    logic batt_smp;
    logic ia_on;
    logic ib_on;
  } state_t;

  localparam state_t STATE_RESET = '{
    bank: RESET_VAL, rdata: 8'h00, sync_d: 1'b0, chop_pol: 1'b0,
    alt_req: 1'b0, div: 2'h0, tick: 1'b0, batt_smp: 1'b0,
    ia_on: 1'b0, ib_on: 1'b0};

endpackage

//--- hw/metering_config_register_bank.sv
// Configuration RAM bank with converter, engine and chop control
`timescale 1ns/1ps
module metering_config_register_bank
  import metering_cfg_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic WAKE,
  input wire logic SLEEP_ENTRY,
  input wire logic MUX_SYNC,
  input wire logic ACCUM_END,
  input wire logic ALT_FRAME,
  output logic CONV_ENABLE,
  output logic BATTERY_LOAD,
  output logic BATTERY_SAMPLE,
  output logic [17:0] BOOT_END_ADDR,
  output logic ENGINE_ENABLE,
  output logic ENGINE_CLK_TICK,
  output logic [14:0] ENGINE_START_ADDR,
  output logic REF_CHOP_POL,
  output logic ALT_MUX_REQ,
  output logic IA_CHOP_ON,
  output logic IB_CHOP_ON
);

  state_t s_reg;
  state_t s_next;
  logic [NREG-1:0] hit;
  logic sync_rise;
  chop_mode_t chop_mode;
  logic fast_sel;
  logic ce_en;
  logic iglob;
  logic [1:0] div_last;

  assign sync_rise = MUX_SYNC & ~s_reg.sync_d;
  assign chop_mode = chop_mode_t'(s_reg.bank[IDX_CHOP][CHOP_LSB +: 2]);
  assign fast_sel = s_reg.bank[IDX_ENGINE][FAST_BIT];
  assign ce_en = s_reg.bank[IDX_ENGINE][CE_EN_BIT];
  assign iglob = s_reg.bank[IDX_IGLOB][IGLOB_BIT];
  assign div_last = fast_sel ? FAST_LAST : SLOW_LAST;

  always_comb
  begin
    s_next = s_reg;
    s_next.alt_req = 1'b0;
    s_next.tick = 1'b0;
    s_next.rdata = 8'h00;
    s_next.sync_d = MUX_SYNC;
    hit = '0;
    for (int i = 0; i < NREG; i++)
    begin
      hit[i] = (ADDR == REG_ADDR[i]);
      if (RD && hit[i])
      begin
        s_next.rdata = s_reg.bank[i] & FIELD_MASK[i] & ~WO_MASK[i];
      end
      if (WR && hit[i])
      begin
        s_next.bank[i] = WDATA & FIELD_MASK[i];
      end
      if (SLEEP_ENTRY)
      begin
        s_next.bank[i] = s_next.bank[i] & ~LOSE_MASK[i];
      end
      if (WAKE)
      begin
        s_next.bank[i] = (s_next.bank[i] & ~WAKE_MASK[i]) |
                         (RESET_VAL[i] & WAKE_MASK[i]);
      end
    end

    if (sync_rise)
    begin
      unique case (chop_mode)
        CHOP_POSITIVE:
        begin
          s_next.chop_pol = 1'b0;
        end
        CHOP_REVERSED:
        begin
          s_next.chop_pol = 1'b1;
        end
        CHOP_TOGGLE_ALT:
        begin
          if (ACCUM_END)
          begin
            s_next.alt_req = 1'b1;
          end
          else
          begin
            s_next.chop_pol = ~s_reg.chop_pol;
          end
        end
        CHOP_TOGGLE:
        begin
          s_next.chop_pol = ~s_reg.chop_pol;
        end
      endcase
    end

    if (s_reg.div >= div_last)
    begin
      s_next.div = 2'h0;
      s_next.tick = ce_en;
    end
    else
    begin
      s_next.div = s_reg.div + 2'h1;
    end

    s_next.batt_smp = s_reg.bank[IDX_BATT][BME_BIT] & ALT_FRAME;
    s_next.ia_on = iglob & s_reg.bank[IDX_ICHAN][IA_BIT];
    s_next.ib_on = iglob & s_reg.bank[IDX_ICHAN][IB_BIT];
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      s_reg <= STATE_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign RDATA = s_reg.rdata;
  assign CONV_ENABLE = s_reg.bank[IDX_CONV][CONV_BIT];
  assign BATTERY_LOAD = s_reg.bank[IDX_BATT][BME_BIT];
  assign BATTERY_SAMPLE = s_reg.batt_smp;
  // boot end in 1 KB pages
  assign BOOT_END_ADDR = {s_reg.bank[IDX_BOOT], {PAGE_SHIFT{1'b0}}};
  assign ENGINE_ENABLE = ce_en;
  assign ENGINE_CLK_TICK = s_reg.tick;
  // program start in 1 KB pages
  assign ENGINE_START_ADDR = {s_reg.bank[IDX_LOC][4:0],
                              {PAGE_SHIFT{1'b0}}};
  assign REF_CHOP_POL = s_reg.chop_pol;
  assign ALT_MUX_REQ = s_reg.alt_req;
  assign IA_CHOP_ON = s_reg.ia_on;
  assign IB_CHOP_ON = s_reg.ib_on;

  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  a_reset_page_values: assert property (
    disable iff (1'b0)
    !RSTN |=> BOOT_END_ADDR == 18'h00400 &&
              ENGINE_START_ADDR == 15'h7C00 && !CONV_ENABLE)
    else $error("Reset values of bank wrong");

  a_wake_loads_values: assert property (
    WAKE |=> ENGINE_START_ADDR == 15'h7C00 &&
             BOOT_END_ADDR == 18'h00400 && !CONV_ENABLE &&
             !ENGINE_ENABLE)
    else $error("Wake did not load initial values");

  a_wake_holds_battery: assert property (
    WAKE && !(WR && ADDR == 16'h2020)
    |=> BATTERY_LOAD == $past(BATTERY_LOAD))
    else $error("Wake changed held field");

  a_read_unused_zero: assert property (
    RD && ADDR == 16'h20A8 |=> RDATA[7:5] == 3'h0 &&
      RDATA[4:0] == $past(ENGINE_START_ADDR[14:10]))
    else $error("Read data wrong");

  a_conv_write_takes: assert property (
    WR && ADDR == 16'h2005 && !WAKE
    |=> CONV_ENABLE == $past(WDATA[3]))
    else $error("Converter enable not written");

  a_battery_immediate: assert property (
    WR && ADDR == 16'h2020 && WDATA[6] && !WAKE
    |=> BATTERY_LOAD ##1 (BATTERY_SAMPLE == $past(ALT_FRAME)))
    else $error("Battery load late");

  a_boot_end_write: assert property (
    WR && ADDR == 16'h20A7 && !WAKE
    |=> BOOT_END_ADDR == {$past(WDATA), 10'h000})
    else $error("Boot end address wrong");

  a_slow_tick_gap: assert property (
    ENGINE_CLK_TICK && !fast_sel ##1 !fast_sel |-> !ENGINE_CLK_TICK [*2])
    else $error("Slow engine clock too fast");

  a_fast_tick_rate: assert property (
    ENGINE_CLK_TICK && fast_sel ##1 fast_sel && ce_en
    |-> !ENGINE_CLK_TICK ##1 ENGINE_CLK_TICK)
    else $error("Fast engine clock wrong rate");

  a_chop_forced: assert property (
    $rose(MUX_SYNC) && chop_mode == CHOP_REVERSED
    |=> REF_CHOP_POL ##0 !ALT_MUX_REQ)
    else $error("Reversed polarity not forced");

  a_chop_holds: assert property (
    !(MUX_SYNC && !$past(MUX_SYNC)) |=> $stable(REF_CHOP_POL))
    else $error("Polarity moved without sync edge");

  a_alt_insert: assert property (
    $rose(MUX_SYNC) && chop_mode == CHOP_TOGGLE_ALT && ACCUM_END
    |=> ALT_MUX_REQ && $stable(REF_CHOP_POL))
    else $error("Alternate frame not inserted");

  a_toggle_plain: assert property (
    $rose(MUX_SYNC) && chop_mode == CHOP_TOGGLE
    |=> !ALT_MUX_REQ && REF_CHOP_POL != $past(REF_CHOP_POL))
    else $error("Polarity did not toggle");

  a_global_gates: assert property (
    WR && ADDR == 16'h20AB && !WDATA[0] && !WAKE
    |=> ##1 !IA_CHOP_ON && !IB_CHOP_ON)
    else $error("Channel chop without global enable");

  a_channel_follows: assert property (
    iglob && WR && ADDR == 16'h20AC && !WAKE
    ##1 iglob
    |=> IA_CHOP_ON == $past(WDATA[0], 2) &&
        IB_CHOP_ON == $past(WDATA[4], 2))
    else $error("Channel chop not following field");

  a_location_write: assert property (
    WR && ADDR == 16'h20A8 && !WAKE
    |=> ENGINE_START_ADDR == {$past(WDATA[4:0]), 10'h000})
    else $error("Engine start address wrong");

  a_slow_tick_period: assert property (
    ENGINE_CLK_TICK && !fast_sel ##1 (!fast_sel && ce_en) [*3]
    |=> ENGINE_CLK_TICK)
    else $error("Slow engine clock too slow");

  a_engine_off_quiet: assert property (
    !ENGINE_ENABLE |=> !ENGINE_CLK_TICK)
    else $error("Engine clock ticks while disabled");

  a_unmapped_read_zero: assert property (
    RD && ADDR[15:12] != 4'h2 |=> RDATA == 8'h00)
    else $error("Read outside bank not zero");

  a_rdata_idle_zero: assert property (
    !RD |=> RDATA == 8'h00)
    else $error("Read data without read strobe");

  a_fields_hold: assert property (
    !WR && !WAKE
    |=> $stable(CONV_ENABLE) && $stable(BOOT_END_ADDR) &&
        $stable(ENGINE_START_ADDR))
    else $error("Field changed without write or wake");

  a_chop_positive: assert property (
    $rose(MUX_SYNC) && chop_mode == CHOP_POSITIVE
    |=> !REF_CHOP_POL && !ALT_MUX_REQ)
    else $error("Positive polarity not forced");

  a_alt_toggle: assert property (
    $rose(MUX_SYNC) && chop_mode == CHOP_TOGGLE_ALT && !ACCUM_END
    |=> !ALT_MUX_REQ && REF_CHOP_POL != $past(REF_CHOP_POL))
    else $error("Polarity did not toggle in mode 00");

  a_alt_single_pulse: assert property (
    ALT_MUX_REQ |=> !ALT_MUX_REQ)
    else $error("Alternate frame request too long");

  a_channel_needs_global: assert property (
    !iglob |=> !IA_CHOP_ON && !IB_CHOP_ON)
    else $error("Channel chop on without global enable");

  a_sample_needs_load: assert property (
    BATTERY_SAMPLE |-> $past(BATTERY_LOAD) && $past(ALT_FRAME))
    else $error("Battery sampled outside alternate frame");

  a_battery_write_clear: assert property (
    WR && ADDR == 16'h2020 && !WDATA[6] |=> !BATTERY_LOAD)
    else $error("Battery load not removed");

  a_wake_chop_values: assert property (
    WAKE |=> chop_mode == CHOP_TOGGLE_ALT && !iglob && !fast_sel)
    else $error("Wake did not load chop and clock values");

  a_wake_beats_write: assert property (
    WAKE && WR && ADDR == 16'h20A7 |=> BOOT_END_ADDR == 18'h00400)
    else $error("Write overrode wake value");

  a_reset_outputs_clear: assert property (
    disable iff (1'b0)
    !RSTN |=> !REF_CHOP_POL && !ALT_MUX_REQ && !ENGINE_CLK_TICK &&
              !IA_CHOP_ON && !IB_CHOP_ON && RDATA == 8'h00)
    else $error("Reset did not clear outputs");

  a_sleep_keeps_fields: assert property (
    SLEEP_ENTRY && !WAKE && !WR |=> $stable(BOOT_END_ADDR))
    else $error("Sleep entry changed kept field");

  c_wake_event: cover property (WAKE ##1 !WAKE);
  c_alt_frame: cover property (ALT_MUX_REQ);
  c_fast_ticks: cover property (
    ENGINE_CLK_TICK && fast_sel ##2 ENGINE_CLK_TICK);
  c_chop_on: cover property (IA_CHOP_ON && IB_CHOP_ON);
  c_battery_sample: cover property (BATTERY_SAMPLE);

endmodule

//--- verif/testbench.sv
// Self-checking testbench for the metering configuration bank
`timescale 1ns/1ps
module testbench;
  import metering_cfg_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, wake = 1'b0, sleep_entry = 1'b0;
  logic mux_sync = 1'b0, accum_end = 1'b0, alt_frame = 1'b0;
  logic [7:0] rdata;
  logic conv, bload, bsmp, ce_en, tick, pol, alt_req, ia, ib;
  logic [17:0] boot_end;
  logic [14:0] start_addr;
  logic [4:0] cnt;
  int n_fail = 0;
  int cmp_count = 0;

  metering_config_register_bank dut_u (
    .CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .WAKE(wake), .SLEEP_ENTRY(sleep_entry),
    .MUX_SYNC(mux_sync), .ACCUM_END(accum_end), .ALT_FRAME(alt_frame),
    .CONV_ENABLE(conv), .BATTERY_LOAD(bload), .BATTERY_SAMPLE(bsmp),
    .BOOT_END_ADDR(boot_end), .ENGINE_ENABLE(ce_en),
    .ENGINE_CLK_TICK(tick), .ENGINE_START_ADDR(start_addr),
    .REF_CHOP_POL(pol), .ALT_MUX_REQ(alt_req), .IA_CHOP_ON(ia),
    .IB_CHOP_ON(ib));

  initial
  begin
    forever #25 clk = ~clk;
  end

  task automatic chk(input string what, input logic [17:0] seen,
    input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk("rdata", rdata, exp);
  endtask

  // Sync rise with accumulation end level; counts request pulses
  task automatic sync_rise(input logic acc);
    @(negedge clk);
    mux_sync = 1'b1;
    accum_end = acc;
    cnt = 5'h00;
    repeat (3)
    begin
      @(negedge clk);
      cnt = cnt + 5'(alt_req);
    end
    mux_sync = 1'b0;
    accum_end = 1'b0;
    @(negedge clk);
  endtask

  task automatic t_reset;
    for (int i = 0; i < NREG; i++)
      rd_chk(REG_ADDR[i], RESET_VAL[i]);
    chk("boot_end", boot_end, 18'h00400);
    chk("start", start_addr, 15'h7C00);
    chk("conv", conv, 1'b0);
    chk("ia_ib", {ia, ib}, 2'h0);
    rd_chk(16'h2001, 8'h00);
  endtask

  task automatic t_fields;
    wr_reg(16'h2005, 8'h08);
    chk("conv", conv, 1'b1);
    rd_chk(16'h2005, 8'h08);
    wr_reg(16'h2005, 8'h00);
    chk("conv", conv, 1'b0);
    wr_reg(16'h20A7, 8'hFF);
    chk("boot_end", boot_end, 18'h3FC00);
    wr_reg(16'h20A8, 8'hFF);
    rd_chk(16'h20A8, 8'h1F);
    wr_reg(16'h20A8, 8'h03);
    chk("start", start_addr, 15'h0C00);
    wr_reg(16'h3005, 8'hFF);
    rd_chk(16'h3005, 8'h00);
    chk("conv", conv, 1'b0);
  endtask

  task automatic t_batt;
    wr_reg(16'h2020, 8'h40);
    chk("bload", bload, 1'b1);
    chk("bsmp", bsmp, 1'b0);
    alt_frame = 1'b1;
    repeat (2) @(negedge clk);
    chk("bsmp", bsmp, 1'b1);
    alt_frame = 1'b0;
    repeat (2) @(negedge clk);
    chk("bsmp", bsmp, 1'b0);
  endtask

  task automatic t_wake;
    wr_reg(16'h2005, 8'h08);
    addr = 16'h20A7;
    wdata = 8'h5A;
    wr = 1'b1;
    wake = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    wake = 1'b0;
    @(negedge clk);
    chk("boot_end", boot_end, 18'h00400);
    rd_chk(16'h20A8, 8'h1F);
    rd_chk(16'h2005, 8'h00);
    rd_chk(16'h2020, 8'h40);
    wr_reg(16'h2020, 8'h00);
    chk("bload", bload, 1'b0);
    wr_reg(16'h20A7, 8'h5A);
    sleep_entry = 1'b1;
    @(negedge clk);
    sleep_entry = 1'b0;
    rd_chk(16'h20A7, 8'h5A);
  endtask

  task automatic t_engine(input logic [7:0] v, input logic [4:0] exp);
    wr_reg(16'h2000, v);
    chk("ce_en", ce_en, v[4]);
    cnt = 5'h00;
    repeat (16)
    begin
      @(negedge clk);
      cnt = cnt + 5'(tick);
    end
    chk("ticks", cnt, exp);
  endtask

  task automatic t_chop;
    wr_reg(16'h2002, 8'h20);
    chk("pol", pol, 1'b0);
    sync_rise(1'b0);
    chk("pol", pol, 1'b1);
    wr_reg(16'h2002, 8'h10);
    sync_rise(1'b1);
    chk("pol", pol, 1'b0);
    chk("alt", cnt, 5'h00);
    wr_reg(16'h2002, 8'h30);
    sync_rise(1'b1);
    chk("pol", pol, 1'b1);
    chk("alt", cnt, 5'h00);
    wr_reg(16'h2002, 8'h00);
    sync_rise(1'b0);
    chk("pol", pol, 1'b0);
    sync_rise(1'b1);
    chk("pol", pol, 1'b0);
    chk("alt", cnt, 5'h01);
  endtask

  task automatic t_ichop;
    wr_reg(16'h20AC, 8'h11);
    chk("ia_ib", {ia, ib}, 2'h0);
    wr_reg(16'h20AB, 8'h01);
    chk("ia_ib", {ia, ib}, 2'h3);
    wr_reg(16'h20AC, 8'h10);
    chk("ia_ib", {ia, ib}, 2'h1);
    wr_reg(16'h20AB, 8'h00);
    chk("ia_ib", {ia, ib}, 2'h0);
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_fields();
    t_batt();
    t_wake();
    t_engine(8'h18, 5'd8);
    t_engine(8'h10, 5'd4);
    t_engine(8'h08, 5'd0);
    t_chop();
    t_ichop();
    report_and_stop();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
endmodule
